/* sync_serial_spi_port.sv */
// Serial peripheral interface port: shift register, receive buffer,
// master clock generation, slave select and interrupt flag
// Assumes a single clk_i domain; serial pins are asynchronous inputs
`timescale 1ns/1ps
`include "spi_port_defines.svh"

// Notes on behaviour
// - select pin used only in select mode, input
// - select low enables shifting and data drive
// - select high releases data out at once
// - select low again resumes at same bit
// - data out pin as input never drives
// - eight bits out and in per byte
// - mode from control and top status bits
// - master drives clock, slave takes clock
// - most significant bit first both ways
// - full byte copies, sets full and flag
// - received byte double buffered
// - write while shifting dropped, collision set
// - buffer read clears full bit
// - shift register reached only via buffer
module sync_serial_spi_port (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rd_data_o,
  output logic            irq_o,
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe_n_o,
  input  wire logic       sdi_i,
  output logic            sdo_o,
  output logic            sdo_oe_n_o,
  input  wire logic       ss_n_i
);
  import spi_port_pkg::*;

  spi_port_pkg::port_state_t cur;
  spi_port_pkg::port_state_t nxt;

  logic [2:0] pins_s;
  logic       sck_s;
  logic       sdi_s;
  logic       ss_s;
  logic       enabled;
  logic       master;
  logic       ckp;
  logic       cke;
  logic       sel_on;
  logic       ss_block;
  logic       busy;
  logic       half_pulse;
  logic       lead_ev;
  logic       trail_ev;
  logic       done;
  logic       wr_buf;
  logic       rd_buf;
  logic       start;
  logic [7:0] shift_in;

  // ----------------------------------------------------------------
  // Pin synchronisers and master clock divider
  // ----------------------------------------------------------------
  pin_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .pins_i  ({ss_n_i, sdi_i, sck_i}),
    .pins_o  (pins_s)
  );

  assign sck_s = pins_s[0];
  assign sdi_s = pins_s[1];
  assign ss_s  = pins_s[2];

  rate_divider u_div (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .run_i   (master && enabled && cur.phase == ph_busy),
    .rate_i  (cur.ctrl[1:0]),
    .pulse_o (half_pulse)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    enabled  = cur.ctrl[`CTRL_EN];
    ckp      = cur.ctrl[`CTRL_CKP];
    cke      = cur.cfg[0];
    master   = cur.ctrl[3:0] < `MODE_SLAVE_SEL;
    sel_on   = cur.ctrl[3:0] == `MODE_SLAVE_SEL
               && cur.porta_dir[`PORTA_SEL_BIT];
    ss_block = sel_on && ss_s;
    busy     = master ? (cur.phase == ph_busy)
                      : (cur.bit_cnt != 4'h0);
    wr_buf   = wr_i && addr_i == `ADDR_DATA_BUF;
    rd_buf   = rd_i && addr_i == `ADDR_DATA_BUF;
    start    = wr_buf && !busy;
  end

  // ----------------------------------------------------------------
  // Serial clock edges: generated in master, sampled in slave
  // ----------------------------------------------------------------
  always_comb begin
    lead_ev  = 1'b0;
    trail_ev = 1'b0;
    if (enabled && master && half_pulse) begin
      lead_ev  = cur.sck_reg == ckp;
      trail_ev = cur.sck_reg != ckp;
    end else if (enabled && !master && !ss_block) begin
      lead_ev  = cur.sck_d == ckp && sck_s != ckp;
      trail_ev = cur.sck_d != ckp && sck_s == ckp;
    end
    // Trailing edge of the eighth bit closes the byte
    done     = trail_ev && cur.bit_cnt == `BITS_PER_BYTE - 4'h1;
    shift_in = {cur.shreg[6:0], cke ? cur.rx_bit : sdi_s};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt         = cur;
    nxt.sck_d   = sck_s;
    nxt.rd_data = 8'h00;

    // Register writes
    if (wr_i) begin
      case (addr_i)
        `ADDR_CONTROL: begin
          nxt.ctrl[5:0] = wr_data_i[5:0];
          // Status flags only clear on a written zero
          if (!wr_data_i[`CTRL_WRITE_COLLISION]) begin
            nxt.ctrl[`CTRL_WRITE_COLLISION] = 1'b0;
          end
          if (!wr_data_i[`CTRL_OVF]) begin
            nxt.ctrl[`CTRL_OVF] = 1'b0;
          end
        end
        `ADDR_STATUS: begin
          nxt.cfg = wr_data_i[`STAT_SMP:`STAT_CKE];
        end
        `ADDR_IRQ_FLAGS: begin
          if (wr_data_i[`IRQ_PORT_BIT]) begin
            nxt.irq_flag = 1'b0;
          end
        end
        `ADDR_IRQ_EN: begin
          nxt.irq_en = wr_data_i[`IRQ_PORT_BIT];
        end
        `ADDR_PORTA_DIR: begin
          nxt.porta_dir = wr_data_i[5:0];
        end
        `ADDR_PIN_DIR: begin
          nxt.sdo_dir = wr_data_i[`PIN_SDO_BIT];
        end
        default: begin
        end
      endcase
    end

    // Data buffer write: load when idle, drop when shifting
    if (wr_buf) begin
      if (busy) begin
        nxt.ctrl[`CTRL_WRITE_COLLISION] = 1'b1;
      end else begin
        nxt.shreg   = wr_data_i;
        nxt.bit_cnt = 4'h0;
        nxt.sck_reg = ckp;
        if (cke) begin
          nxt.out_bit = wr_data_i[7];
        end
        if (master && enabled) begin
          nxt.phase = ph_busy;
        end
      end
    end

    // Register reads, answered in the next cycle
    if (rd_i) begin
      case (addr_i)
        `ADDR_DATA_BUF:  nxt.rd_data = cur.rx_buf;
        `ADDR_CONTROL:   nxt.rd_data = cur.ctrl;
        `ADDR_STATUS:    nxt.rd_data = {cur.cfg, 5'h00, cur.bf};
        `ADDR_IRQ_FLAGS: nxt.rd_data = {4'h0, cur.irq_flag, 3'h0};
        `ADDR_IRQ_EN:    nxt.rd_data = {4'h0, cur.irq_en, 3'h0};
        `ADDR_PORTA_DIR: nxt.rd_data = {2'h0, cur.porta_dir};
        `ADDR_PIN_DIR:   nxt.rd_data = {7'h00, cur.sdo_dir};
        default:         nxt.rd_data = 8'h00;
      endcase
    end
    if (rd_buf) begin
      nxt.bf = 1'b0;
    end

    // Shifting
    if (enabled && master && half_pulse) begin
      nxt.sck_reg = !cur.sck_reg;
    end
    if (lead_ev) begin
      if (cke) begin
        nxt.rx_bit = sdi_s;
      end else begin
        nxt.out_bit = cur.shreg[7];
      end
    end
    if (trail_ev) begin
      nxt.shreg   = shift_in;
      nxt.bit_cnt = cur.bit_cnt + 4'h1;
      if (cke) begin
        nxt.out_bit = cur.shreg[6];
      end
    end
    if (done) begin
      // Receive buffer decouples software from the shifter
      nxt.rx_buf   = shift_in;
      nxt.bit_cnt  = 4'h0;
      nxt.phase    = ph_idle;
      nxt.bf       = 1'b1;
      nxt.irq_flag = 1'b1;
      if (cur.bf && !rd_buf) begin
        nxt.ctrl[`CTRL_OVF] = 1'b1;
      end
    end

    // Disabling the port abandons any partial byte
    if (!nxt.ctrl[`CTRL_EN]) begin
      nxt.bit_cnt = 4'h0;
      nxt.phase   = ph_idle;
      nxt.sck_reg = nxt.ctrl[`CTRL_CKP];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur           <= '0;
      cur.ctrl      <= `CTRL_RESET;
      cur.porta_dir <= `PORTA_DIR_RESET;
      cur.sdo_dir   <= `PIN_DIR_RESET;
      cur.phase     <= ph_idle;
    end else begin
      cur <= nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_o  = cur.rd_data;
  assign irq_o      = cur.irq_flag && cur.irq_en;
  assign sck_o      = cur.sck_reg;
  assign sck_oe_n_o = !(enabled && master);
  assign sdo_o      = cur.out_bit;
  // Released while disabled, set as input, or deselected
  assign sdo_oe_n_o = !(enabled && !cur.sdo_dir && !ss_block);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sel_ignored_a: assert property (
    (enabled && cur.ctrl[3:0] == `MODE_SLAVE_SEL && !cur.sdo_dir
     && !cur.porta_dir[`PORTA_SEL_BIT]) |-> !sdo_oe_n_o)
    else $error("select honoured with pin set as output");

  sel_drive_a: assert property (
    (enabled && sel_on && !ss_s && !cur.sdo_dir) |-> !sdo_oe_n_o)
    else $error("data out not driven while selected");

  sel_release_a: assert property (
    (sel_on && ss_s) |-> sdo_oe_n_o)
    else $error("data out driven while deselected");

  bit_hold_a: assert property (
    (sel_on && ss_s && !wr_buf && $past(sel_on && ss_s)
     && !(wr_i && addr_i == `ADDR_CONTROL))
    |=> $stable(cur.bit_cnt))
    else $error("bit position moved while deselected");

  input_only_a: assert property (
    cur.sdo_dir |-> sdo_oe_n_o)
    else $error("data out driven while set as input");

  byte_done_a: assert property (
    done |=> cur.bf && cur.irq_flag && cur.rx_buf == $past(shift_in))
    else $error("byte end did not fill buffer and flag");

  collision_a: assert property (
    (wr_buf && busy) |=> cur.ctrl[`CTRL_WRITE_COLLISION]
    && cur.shreg == $past(trail_ev ? shift_in : cur.shreg))
    else $error("write during shifting not dropped");

  read_clear_a: assert property (
    (rd_buf && !done) |=> !cur.bf)
    else $error("buffer read left full bit set");

  msb_first_a: assert property (
    (start && cke && !trail_ev) |=> sdo_o == $past(wr_data_i[7]))
    else $error("first bit out is not the top bit");

  clock_dir_a: assert property (
    (enabled && !master) |-> sck_oe_n_o)
    else $error("clock pin driven in slave mode");

  count_clear_a: assert property (
    done |=> cur.bit_cnt == 4'h0)
    else $error("bit count not cleared at byte end");

  buf_hold_a: assert property (
    (trail_ev && !done) |=> $stable(cur.rx_buf))
    else $error("receive buffer changed in mid-byte");

  cfg_store_a: assert property (
    (wr_i && addr_i == `ADDR_STATUS)
    |=> cur.cfg == $past(wr_data_i[`STAT_SMP:`STAT_CKE]))
    else $error("status configuration bits not stored");

  start_load_a: assert property (
    (start && master && enabled)
    |=> cur.phase == ph_busy && cur.shreg == $past(wr_data_i))
    else $error("idle buffer write did not start a byte");

  shift_freeze_a: assert property (
    (ss_block && !wr_buf) |=> $stable(cur.shreg))
    else $error("shifter moved while deselected");

  buf_read_a: assert property (
    rd_buf |=> rd_data_o == $past(cur.rx_buf))
    else $error("buffer read did not return received byte");

  master_clock_a: assert property (
    (enabled && master) |-> !sck_oe_n_o)
    else $error("clock pin not driven in master mode");
endmodule

/* spi_port_defines.svh */
// Register map, field positions, reset values and timing counts
// Assumes inclusion by bare name from the serial port design files
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_DATA_BUF   3'h0
`define ADDR_CONTROL    3'h1
`define ADDR_STATUS     3'h2
`define ADDR_IRQ_FLAGS  3'h3
`define ADDR_IRQ_EN     3'h4
`define ADDR_PORTA_DIR  3'h5
`define ADDR_PIN_DIR    3'h6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_WRITE_COLLISION       7
`define CTRL_OVF        6
`define CTRL_EN         5
`define CTRL_CKP        4
`define STAT_SMP        7
`define STAT_CKE        6
`define STAT_BF         0
`define IRQ_PORT_BIT    3
`define PORTA_SEL_BIT   5
`define PIN_SDO_BIT     0

// ----------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------
`define MODE_SLAVE_SEL  4'h4
`define MODE_SLAVE_FREE 4'h5
`define CTRL_RESET      8'h00
`define PORTA_DIR_RESET 6'h3f
`define PIN_DIR_RESET   1'b1

// ----------------------------------------------------------------
// Timing: master half period is HALF_BASE << (2 * rate code)
// ----------------------------------------------------------------
`define HALF_BASE       8'h02
`define BITS_PER_BYTE   4'h8

`endif

/* spi_port_pkg.sv */
// Types shared by the serial port design files
// Assumes nothing beyond a SystemVerilog compiler
package spi_port_pkg;

  typedef enum logic {
    ph_idle,
    ph_busy
  } phase_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] cfg;
    logic       bf;
    logic       irq_flag;
    logic       irq_en;
    logic [5:0] porta_dir;
    logic       sdo_dir;
    logic [7:0] rx_buf;
    logic [7:0] shreg;
    logic       rx_bit;
    logic       out_bit;
    logic [3:0] bit_cnt;
    logic       sck_reg;
    logic       sck_d;
    phase_t     phase;
    logic [7:0] rd_data;
  } port_state_t;

  typedef struct packed {
    logic [7:0] count;
  } div_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sync_state_t;

endpackage

/* pin_sync.sv */
// Two flip-flop synchronisers for the serial pins
// Assumes pins are asynchronous to clk_i
`timescale 1ns/1ps
module pin_sync (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [2:0] pins_i,
  output logic      [2:0] pins_o
);
  import spi_port_pkg::*;

  spi_port_pkg::sync_state_t cur;
  spi_port_pkg::sync_state_t nxt;

  always_comb begin
    nxt    = cur;
    nxt.s1 = pins_i;
    nxt.s2 = cur.s1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign pins_o = cur.s2;
endmodule

/* rate_divider.sv */
// Half period enable pulse for the master serial clock
// Assumes run_i stays high for the whole byte
`timescale 1ns/1ps
`include "spi_port_defines.svh"
module rate_divider (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       run_i,
  input  wire logic [1:0] rate_i,
  output logic            pulse_o
);
  import spi_port_pkg::*;

  spi_port_pkg::div_state_t cur;
  spi_port_pkg::div_state_t nxt;
  logic [7:0] half;

  always_comb begin
    half = `HALF_BASE << {rate_i, 1'b0};
    nxt  = cur;
    if (!run_i || cur.count == half - 8'h01) begin
      nxt.count = 8'h00;
    end else begin
      nxt.count = cur.count + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign pulse_o = run_i && (cur.count == half - 8'h01);
endmodule

/* spi_far_model.sv */
// Behavioural far-side serial device acting as slave or as master
// Assumes the bench resolves the shared clock and data lines
`timescale 1ns/1ps
module spi_far_model (
  input  wire logic sck_line_i,
  input  wire logic sdo_line_i,
  input  wire logic sdo_oe_n_i,
  output logic      sck_o,
  output logic      sdi_o,
  output logic      ss_n_o
);
  logic       master;
  logic [7:0] sh;
  logic [7:0] rx;
  logic       run_oe_n;
  logic       pause_oe_n;
  logic       late;

  initial begin
    master     = 1'b0;
    sck_o      = 1'b0;
    sdi_o      = 1'b0;
    ss_n_o     = 1'b1;
    sh         = 8'h00;
    rx         = 8'h00;
    run_oe_n   = 1'b0;
    pause_oe_n = 1'b0;
    late       = 1'b0;
  end

  // ------------------------------------------------------------
  // Slave role: late clear samples leading and shifts trailing;
  // late set shifts on the leading edge and samples trailing
  // ------------------------------------------------------------
  always @(posedge sck_line_i) begin
    if (!master && !late) begin
      rx = {rx[6:0], sdo_line_i};
    end else if (!master) begin
      sdi_o = sh[7];
      sh = {sh[6:0], 1'b0};
    end
  end

  always @(negedge sck_line_i) begin
    if (!master && late) begin
      rx = {rx[6:0], sdo_line_i};
    end else if (!master) begin
      sh = {sh[6:0], 1'b0};
      sdi_o = sh[7];
    end
  end

  task automatic load(input logic [7:0] b);
    sh = b;
    sdi_o = b[7];
  endtask

  // ------------------------------------------------------------
  // Master role: 200 ns clock, select may lift before bit pause
  // ------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx, input int pause);
    master = 1'b1;
    ss_n_o = 1'b0;
    #300;
    run_oe_n = sdo_oe_n_i;
    for (int i = 0; i < 8; i++) begin
      if (i == pause) begin
        #100;
        ss_n_o = 1'b1;
        #300;
        pause_oe_n = sdo_oe_n_i;
        ss_n_o = 1'b0;
        #300;
      end
      sdi_o = tx[7 - i];
      #100;
      sck_o = 1'b1;
      #90;
      rx = {rx[6:0], sdo_line_i};
      #10;
      sck_o = 1'b0;
    end
    #300;
    ss_n_o = 1'b1;
    sdi_o = ~sdi_o;
    master = 1'b0;
  endtask
endmodule

/* sync_serial_spi_port_tb.sv */
// Self-checking bench for the serial port: registers, master and slave
// Assumes the far-side model and the design defines header
`timescale 1ns/1ps
`include "spi_port_defines.svh"
module sync_serial_spi_port_tb;
  logic       clk_i, reset_i, wr_i, rd_i;
  logic [2:0] addr_i;
  logic [7:0] wr_data_i, rd_data_o, d;
  logic       irq_o, sck_o, sck_oe_n_o, sdo_o, sdo_oe_n_o;
  logic       p_sck, p_sdi, p_ss_n, sck_line, sdo_line;
  int         error_cnt, n_tests;

  // Released data line shows the inverse of the driven value; released clock line carries the far model's clock
  assign sck_line = sck_oe_n_o ? p_sck : sck_o;
  assign sdo_line = sdo_oe_n_o ? ~sdo_o : sdo_o;

  sync_serial_spi_port DUT (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .addr_i     (addr_i),
    .wr_data_i  (wr_data_i),
    .wr_i       (wr_i),
    .rd_i       (rd_i),
    .rd_data_o  (rd_data_o),
    .irq_o      (irq_o),
    .sck_i      (sck_line),
    .sck_o      (sck_o),
    .sck_oe_n_o (sck_oe_n_o),
    .sdi_i      (p_sdi),
    .sdo_o      (sdo_o),
    .sdo_oe_n_o (sdo_oe_n_o),
    .ss_n_i     (p_ss_n)
  );

  spi_far_model far (
    .sck_line_i (sck_line),
    .sdo_line_i (sdo_line),
    .sdo_oe_n_i (sdo_oe_n_o),
    .sck_o      (p_sck),
    .sdi_o      (p_sdi),
    .ss_n_o     (p_ss_n)
  );

  initial begin
    clk_i = 1'b0;
    forever begin
      #12.5 clk_i = ~clk_i;
    end
  end

  // ------------------------------------------------------------
  // Bus tasks and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    wr_i      <= 1'b1;
    addr_i    <= a;
    wr_data_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  task automatic wait_full();
    int k;
    k = 0;
    d = 8'h00;
    while (d[0] !== 1'b1 && k < 600) begin
      rd(`ADDR_STATUS);
      k++;
    end
    chk({7'h00, d[0]}, 8'h01);
  endtask

  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 10000);
    error_cnt++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    results();
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    reset_i   = 1'b1;
    wr_i      = 1'b0;
    rd_i      = 1'b0;
    addr_i    = 3'h0;
    wr_data_i = 8'h00;
    error_cnt = 0;
    n_tests   = 0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    chk({6'h00, sck_oe_n_o, sdo_oe_n_o}, 8'h03);
    rdc(`ADDR_CONTROL, 8'h00);
    rdc(`ADDR_STATUS, 8'h00);
    rdc(`ADDR_IRQ_FLAGS, 8'h00);
    rdc(`ADDR_IRQ_EN, 8'h00);
    rdc(`ADDR_PORTA_DIR, 8'h3f);
    rdc(`ADDR_PIN_DIR, 8'h01);
    rdc(3'h7, 8'h00);
    // Master, rate 1, with a collision
    wr(`ADDR_PIN_DIR, 8'h00);
    wr(`ADDR_STATUS, 8'h40);
    wr(`ADDR_IRQ_EN, 8'h08);
    far.load(8'h3c);
    wr(`ADDR_CONTROL, 8'h21);
    wr(`ADDR_DATA_BUF, 8'ha5);
    wr(`ADDR_DATA_BUF, 8'h11);
    chk({6'h00, sck_oe_n_o, sdo_oe_n_o}, 8'h00);
    rdc(`ADDR_CONTROL, 8'ha1);
    wait_full();
    chk({7'h00, irq_o}, 8'h01);
    chk(far.rx, 8'ha5);
    rdc(`ADDR_DATA_BUF, 8'h3c);
    rdc(`ADDR_STATUS, 8'h40);
    wr(`ADDR_IRQ_FLAGS, 8'h08);
    chk({7'h00, irq_o}, 8'h00);
    // Master, rate 2, interrupt masked, next byte before reading
    wr(`ADDR_CONTROL, 8'h22);
    wr(`ADDR_IRQ_EN, 8'h00);
    far.load(8'hc3);
    wr(`ADDR_DATA_BUF, 8'h5a);
    wait_full();
    rdc(`ADDR_IRQ_FLAGS, 8'h08);
    chk({7'h00, irq_o}, 8'h00);
    chk(far.rx, 8'h5a);
    far.load(8'h81);
    wr(`ADDR_DATA_BUF, 8'h00);
    repeat (40) @(posedge clk_i);
    rdc(`ADDR_DATA_BUF, 8'hc3);
    wait_full();
    rdc(`ADDR_DATA_BUF, 8'h81);
    rdc(`ADDR_CONTROL, 8'h22);
    // Master, rate 2, data out on the leading clock edge
    wr(`ADDR_STATUS, 8'h00);
    far.late = 1'b1;
    far.load(8'he7);
    wr(`ADDR_DATA_BUF, 8'h4b);
    wait_full();
    chk(far.rx, 8'h4b);
    rdc(`ADDR_DATA_BUF, 8'he7);
    far.late = 1'b0;
    wr(`ADDR_STATUS, 8'h40);
    // Slave with select, select lifted in mid-byte
    wr(`ADDR_CONTROL, 8'h24);
    wr(`ADDR_DATA_BUF, 8'h96);
    chk({6'h00, sck_oe_n_o, sdo_oe_n_o}, 8'h03);
    far.xfer(8'h69, 3);
    chk({6'h00, far.run_oe_n, far.pause_oe_n}, 8'h01);
    chk(far.rx, 8'h96);
    rdc(`ADDR_DATA_BUF, 8'h69);
    // Select ignored when its pin is an output; data pin as input
    wr(`ADDR_PORTA_DIR, 8'h1f);
    chk({6'h00, sck_oe_n_o, sdo_oe_n_o}, 8'h02);
    wr(`ADDR_PIN_DIR, 8'h01);
    chk({6'h00, sck_oe_n_o, sdo_oe_n_o}, 8'h03);
    results();
  end
endmodule
